// ==== hw/dcd_decoder.sv ====
// Purpose: command decoder, bank row state and write mask of the memory device
// Assumes: link clock and pins sampled by sys_clk, far slower than sys_clk
// Notes:   commands are taken at rising edges of the sampled link clock
//          refused commands pulse cmd_error and change no bank state
//
// Notes on behaviour
// - activate to idle bank opens given row
// - row stays open until bank precharged
// - precharge closes one bank, A10 high all
// - access to other bank during auto precharge
// - precharged bank idle, activate before access
// - repeat precharge accepted, timer restarts
// - write decode, A10 requests auto precharge
// - read decode, A10 requests auto precharge
// - A12 low chops burst when on-the-fly enabled
// - idle: mode set, refresh, ZQ long/short
// - NOP registers no new command
// - CS high deselects, no new command
// - NOP and deselect leave operations running
// - CKE falling enters power-down or self-refresh
// - CKE rising with NOP/deselect exits
// - mask high suppresses its byte lane
// - classify power moves from previous CKE
// - CS counts as part of command code
// - lower mask low byte, upper mask high
`timescale 1ns/100ps
module dcd_decoder
	import dcd_pkg::*;
#(
	parameter int unsigned PRE_CK = PRE_CK_DEF  // precharge period, link cycles
) (
	input  wire logic                 sys_clk,        // core clock, 250 MHz
	input  wire logic                 reset_n,        // asynchronous reset, active low
	input  wire logic                 ck_in,          // link clock pin
	input  wire dcd_pins_type         pins,           // command and address pins
	input  wire logic                 otf_en,         // burst length chosen per command
	input  wire logic                 fixed_bc4,      // fixed length is chop of four
	input  wire logic                 wr_beat_valid,  // write beat from data path
	input  wire logic [DQ_W-1:0]      wr_beat_data,   // write beat data
	input  wire logic [DM_W-1:0]      wr_beat_mask,   // beat masks, bit 1 upper byte
	output logic                      cmd_valid,      // one-cycle command pulse
	output dcd_cmd_type               cmd,            // decoded command
	output logic                      cmd_error,      // one-cycle illegal command pulse
	output logic      [ADDR_W-1:0]    open_row,       // row of cmd bank, next cycle
	output logic      [NUM_BANKS-1:0] bank_open,      // row open per bank
	output logic      [NUM_BANKS-1:0] bank_pre,       // precharge running per bank
	output dcd_pwr_type               power_state,    // run, power-down, self-refresh
	output logic                      arr_wr_valid,   // write beat to the array
	output logic      [DQ_W-1:0]      arr_wr_data,    // beat data
	output logic      [DM_W-1:0]      arr_wr_be       // byte enables
);

	// everything the decoder remembers but the rows, registered as one word
	typedef struct packed {
		dcd_pins_type                        s1;
		dcd_pins_type                        s2;
		logic                                ck1;
		logic                                ck2;
		logic                                ck_d;
		logic                                cke_prev;
		dcd_pwr_type                         pwr;
		logic [NUM_BANKS-1:0]                open;
		logic [NUM_BANKS-1:0]                pre;
		logic [NUM_BANKS-1:0][TMR_W-1:0]     tmr;
		logic                                cmd_valid;
		logic                                cmd_error;
		dcd_cmd_type                         cmd;
		logic                                wr_valid;
		logic [DQ_W-1:0]                     wr_data;
		logic [DM_W-1:0]                     wr_be;
	} dcd_dec_state_type;

	// current and next value of that word
	dcd_dec_state_type state_q;
	dcd_dec_state_type state_d;

	// row store write port, filled by the decode
	logic              mem_we;
	logic [BA_W-1:0]   mem_wa;
	logic [ADDR_W-1:0] mem_wd;

	// next state: sampling, decode, bank bookkeeping, write masking
	always_comb begin
		// locals of the decode, all set at the top
		dcd_pins_type     p;
		dcd_cmd_code_type code;
		logic             ck_rise;
		logic             post;
		logic             err;
		logic             all_idle;
		logic             quiet;
		logic             bc4;
		logic             ap;
		p        = state_q.s2;
		code     = CMD_DES;
		ck_rise  = state_q.ck2 & ~state_q.ck_d;
		post     = 1'b0;
		err      = 1'b0;
		all_idle = ~|(state_q.open | state_q.pre);
		quiet    = p.cs_n | (p.ras_n & p.cas_n & p.we_n);
		bc4      = otf_en ? ~p.addr[BC_BIT] : fixed_bc4;
		ap       = p.addr[AP_BIT];
		state_d  = state_q;
		mem_we   = 1'b0;
		mem_wa   = p.ba;
		mem_wd   = p.addr;

		// two-flop synchronisers; first stages feed only second stages
		state_d.s1   = pins;
		state_d.ck1  = ck_in;
		state_d.s2   = state_q.s1;
		state_d.ck2  = state_q.ck1;
		state_d.ck_d = state_q.ck2;

		// command pulses last one cycle
		state_d.cmd_valid = 1'b0;
		state_d.cmd_error = 1'b0;

		// write beats: a set mask bit drops its lane
		state_d.wr_valid = wr_beat_valid;
		if (wr_beat_valid) begin
			state_d.wr_data = wr_beat_data;
			state_d.wr_be   = ~wr_beat_mask;
		end

		// a link edge is seen as exactly one core cycle of ck_rise
		if (ck_rise) begin
			state_d.cke_prev = p.cke;

			// bank timers run on every link edge, whatever the command
			for (int b = 0; b < NUM_BANKS; b++) begin
				if (state_q.tmr[b] != '0) begin
					state_d.tmr[b] = state_q.tmr[b] - 8'h01;
					if (state_q.tmr[b] == 8'h01) begin
						state_d.pre[b] = 1'b0;
					end
				end
			end

			// classify by previous and current clock enable
			// both high: an ordinary command by its code
			if (state_q.cke_prev && p.cke) begin
				post = 1'b1;
				if (p.cs_n) begin
					code = CMD_DES;
				end else begin
					unique case ({p.ras_n, p.cas_n, p.we_n})
						3'b111: code = CMD_NOP;
						3'b011: code = CMD_ACT;
						3'b010: code = ap ? CMD_PREA : CMD_PRE;
						3'b101: code = CMD_RD;
						3'b100: code = CMD_WR;
						3'b000: code = CMD_MRS;
						3'b001: code = CMD_REF;
						3'b110: code = ap ? CMD_ZQL : CMD_ZQS;
					endcase
				end
			end else if (state_q.cke_prev && !p.cke) begin
				// clock enable falling: low-power entry
				post = 1'b1;
				if (quiet) begin
					code = CMD_PDE;
				end else if (!p.ras_n && !p.cas_n && p.we_n && all_idle) begin
					code = CMD_SRE;
				end else begin
					code = CMD_NOP;
					err  = 1'b1;
				end
			end else if (!state_q.cke_prev && p.cke) begin
				// clock enable rising: low-power exit
				post = 1'b1;
				if (quiet) begin
					unique case (state_q.pwr)
						PW_SREF: code = CMD_SRX;
						PW_PDN:  code = CMD_PDX;
						PW_RUN:  code = CMD_PDX;
					endcase
				end else begin
					code = CMD_NOP;
					err  = 1'b1;
				end
			end

			// carry out the command
			unique case (code)
				CMD_ACT: begin
					// an open or still precharging bank refuses activation
					if (state_q.open[p.ba] || state_q.pre[p.ba]) begin
						err = 1'b1;
					end else begin
						state_d.open[p.ba] = 1'b1;
						mem_we             = 1'b1;
					end
				end
				CMD_RD, CMD_WR: begin
					// only the addressed bank matters; others may precharge
					if (!state_q.open[p.ba]) begin
						err = 1'b1;
					end else if (ap) begin
						state_d.open[p.ba] = 1'b0;
						state_d.pre[p.ba]  = 1'b1;
						// burst first, then the precharge period
						state_d.tmr[p.ba]  = bc4 ? TMR_W'(BC4_CK + PRE_CK)
						                         : TMR_W'(BL8_CK + PRE_CK);
					end
				end
				CMD_PRE: begin
					// idle or precharging bank accepted, period restarts
					state_d.open[p.ba] = 1'b0;
					state_d.pre[p.ba]  = 1'b1;
					state_d.tmr[p.ba]  = TMR_W'(PRE_CK);
				end
				CMD_PREA: begin
					// every bank closes and restarts its period
					for (int b = 0; b < NUM_BANKS; b++) begin
						state_d.open[b] = 1'b0;
						state_d.pre[b]  = 1'b1;
						state_d.tmr[b]  = TMR_W'(PRE_CK);
					end
				end
				CMD_MRS, CMD_REF, CMD_ZQL, CMD_ZQS: begin
					// idle-state commands need every bank closed and settled
					if (!all_idle) begin
						err = 1'b1;
					end
				end
				// power state follows entry and exit
				CMD_PDE: begin
					state_d.pwr = PW_PDN;
				end
				CMD_SRE: begin
					state_d.pwr = PW_SREF;
				end
				CMD_PDX, CMD_SRX: begin
					// either exit returns to the running state
					state_d.pwr = PW_RUN;
				end
				default: begin
					// NOP and deselect change nothing
					err = err;
				end
			endcase

			// publish the command and its side flags
			if (post) begin
				state_d.cmd_valid     = 1'b1;
				state_d.cmd_error     = err;
				state_d.cmd.code      = code;
				state_d.cmd.ba        = p.ba;
				state_d.cmd.addr      = p.addr;
				state_d.cmd.auto_pre  = ap;
				state_d.cmd.bc4       = bc4;
			end
			// a refused command leaves the row store alone
			if (err) begin
				mem_we = 1'b0;
			end
		end
	end

	// state register
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			// power state and clock enable start at their idle values
			state_q          <= '0;
			state_q.pwr      <= PW_RUN;
			state_q.cke_prev <= CKE_RST;
			state_q.open     <= BANKS_RST;
			state_q.pre      <= BANKS_RST;
		end else begin
			state_q <= state_d;
		end
	end

	// row store, read follows the published command's bank
	dcd_row_mem #(
		.DEPTH (NUM_BANKS),
		.AW    (BA_W),
		.DW    (ADDR_W)
	) u_row_mem (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.wr_en   (mem_we),
		.wr_addr (mem_wa),
		.wr_data (mem_wd),
		.rd_addr (state_q.cmd.ba),
		.rd_data (open_row)
	);

	// outputs straight from the state register
	// data outputs are flops; nothing here is combinational
	assign cmd_valid    = state_q.cmd_valid;
	assign cmd          = state_q.cmd;
	assign cmd_error    = state_q.cmd_error;
	assign bank_open    = state_q.open;
	assign bank_pre     = state_q.pre;
	assign power_state  = state_q.pwr;
	assign arr_wr_valid = state_q.wr_valid;
	assign arr_wr_data  = state_q.wr_data;
	assign arr_wr_be    = state_q.wr_be;

endmodule : dcd_decoder

// ==== hw/dcd_row_mem.sv ====
// Purpose: open-row store, one word per bank
// Assumes: one write port, one read port, same clock
// Notes:   read data come from a register, one cycle after the address
`timescale 1ns/100ps
module dcd_row_mem
	import dcd_pkg::*;
#(
	parameter int unsigned DEPTH = NUM_BANKS,
	parameter int unsigned AW    = BA_W,
	parameter int unsigned DW    = ADDR_W
) (
	input  wire logic          sys_clk,  // core clock
	input  wire logic          reset_n,  // asynchronous reset, active low
	input  wire logic          wr_en,    // write strobe
	input  wire logic [AW-1:0] wr_addr,  // bank written
	input  wire logic [DW-1:0] wr_data,  // row written
	input  wire logic [AW-1:0] rd_addr,  // bank read
	output logic      [DW-1:0] rd_data   // registered row
);

	typedef struct packed {
		logic [DEPTH-1:0][DW-1:0] mem;
		logic [DW-1:0]            rd;
	} dcd_mem_state_type;

	dcd_mem_state_type state_q;
	dcd_mem_state_type state_d;

	// write then registered read
	always_comb begin
		state_d = state_q;
		if (wr_en) begin
			state_d.mem[wr_addr] = wr_data;
		end
		state_d.rd = state_q.mem[rd_addr];
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign rd_data = state_q.rd;

endmodule : dcd_row_mem

// ==== inc/dcd_pkg.sv ====
// Purpose: shared constants and types of the command decoder
// Assumes: sixteen-bit data bus, eight banks, thirteen row address bits
// Notes:   widths and counts are defaults; timing counts are in link clock cycles
package dcd_pkg;

	// geometry of the array
	localparam int unsigned NUM_BANKS = 8;
	localparam int unsigned BA_W      = 3;
	localparam int unsigned ADDR_W    = 13;
	localparam int unsigned DQ_W      = 16;
	localparam int unsigned DM_W      = 2;

	// address bit positions with a command meaning
	localparam int unsigned AP_BIT = 10;   // auto precharge / all banks
	localparam int unsigned BC_BIT = 12;   // burst chop on the fly, low = chop

	// bank timer width and default counts (link clock cycles)
	localparam int unsigned TMR_W      = 8;
	localparam int unsigned PRE_CK_DEF = 4;   // precharge period
	localparam int unsigned BL8_CK     = 4;   // eight-beat burst on the link
	localparam int unsigned BC4_CK     = 2;   // chopped four-beat burst

	// reset values
	localparam logic [NUM_BANKS-1:0] BANKS_RST = 8'h00;
	localparam logic                 CKE_RST   = 1'h0;

	// power state, one-hot
	typedef enum logic [2:0] {
		PW_RUN  = 3'b001,
		PW_PDN  = 3'b010,
		PW_SREF = 3'b100
	} dcd_pwr_type;

	// decoded command codes
	typedef enum logic [3:0] {
		CMD_DES  = 4'h0,
		CMD_NOP  = 4'h1,
		CMD_ACT  = 4'h2,
		CMD_RD   = 4'h3,
		CMD_WR   = 4'h4,
		CMD_PRE  = 4'h5,
		CMD_PREA = 4'h6,
		CMD_MRS  = 4'h7,
		CMD_REF  = 4'h8,
		CMD_ZQL  = 4'h9,
		CMD_ZQS  = 4'hA,
		CMD_PDE  = 4'hB,
		CMD_PDX  = 4'hC,
		CMD_SRE  = 4'hD,
		CMD_SRX  = 4'hE
	} dcd_cmd_code_type;

	// command and address pins, all active levels as on the wire
	typedef struct packed {
		logic              cke;
		logic              cs_n;
		logic              ras_n;
		logic              cas_n;
		logic              we_n;
		logic [BA_W-1:0]   ba;
		logic [ADDR_W-1:0] addr;
	} dcd_pins_type;

	// one decoded command
	typedef struct packed {
		dcd_cmd_code_type  code;
		logic [BA_W-1:0]   ba;
		logic [ADDR_W-1:0] addr;
		logic              auto_pre;
		logic              bc4;
	} dcd_cmd_type;

endpackage : dcd_pkg

// ==== sim/dcd_ctl_model.sv ====
// Purpose: memory controller model driving link clock and command pins
// Assumes: link half period of 20 core cycles, free running
// Notes:   one queued command per link cycle, deselect otherwise
`timescale 1ns/100ps
module dcd_ctl_model
	import dcd_pkg::*;
(
	input  wire logic   sys_clk, // core clock
	output logic         ck_in,  // link clock
	output dcd_pins_type pins    // command and address pins
);
	dcd_pins_type q[$];          // commands waiting for a link cycle
	int           cnt = 0;       // core cycles in the half period
	logic         cke_lvl = 1'b0; // clock enable kept between commands
	initial begin
		ck_in = 1'b0;
		pins = 21'h080000;
	end
	// pins move on the falling link edge, far from the sampling edge
	always @(negedge sys_clk) begin
		cnt = (cnt == 19) ? 0 : cnt + 1;
		if (cnt == 0) begin
			ck_in = ~ck_in;
			if (!ck_in && q.size() != 0) begin
				pins = q.pop_front();
				cke_lvl = pins.cke;
			end else if (!ck_in) begin
				pins = ~pins;         // released lines never keep their value
				pins.cs_n = 1'b1;     // deselect between commands
				pins.cke = cke_lvl;   // enable level holds across idle cycles
			end
		end
	end
	task automatic push(input dcd_pins_type p);
		q.push_back(p);
	endtask : push
endmodule : dcd_ctl_model

// ==== sim/dcd_decoder_assertions.sv ====
// Purpose: port checker of the command decoder
// Assumes: one core clock domain, reset active low
// Notes:   bound to every instance of the decoder
`timescale 1ns/100ps
module dcd_decoder_assertions
	import dcd_pkg::*;
(
	input wire logic                 sys_clk,       // core clock
	input wire logic                 reset_n,       // reset, active low
	input wire logic                 wr_beat_valid, // beat in
	input wire logic [DQ_W-1:0]      wr_beat_data,  // beat data in
	input wire logic [DM_W-1:0]      wr_beat_mask,  // beat masks in
	input wire logic                 cmd_valid,     // command pulse
	input wire dcd_cmd_type          cmd,           // decoded command
	input wire logic                 cmd_error,     // refused pulse
	input wire logic [ADDR_W-1:0]    open_row,      // row of cmd bank
	input wire logic [NUM_BANKS-1:0] bank_open,     // open banks
	input wire logic [NUM_BANKS-1:0] bank_pre,      // precharging banks
	input wire dcd_pwr_type          power_state,   // power state
	input wire logic                 arr_wr_valid,  // beat out
	input wire logic [DQ_W-1:0]      arr_wr_data,   // beat data out
	input wire logic [DM_W-1:0]      arr_wr_be      // byte enables out
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	logic [NUM_BANKS-1:0] open_q; // bank state before the command edge
	wire                  ok = cmd_valid && !cmd_error;
	wire                  rw = cmd.code == CMD_RD || cmd.code == CMD_WR;
	// delay open state so a command is judged against the state it found
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) open_q <= '0;
		else open_q <= bank_open;
	end
	// an accepted activate opens the bank, its row shows a cycle later
	sequence s_act;
		ok && cmd.code == CMD_ACT;
	endsequence
	sequence s_open_row;
		bank_open[cmd.ba] ##1 open_row == cmd.addr;
	endsequence
	AST_ERR_PAIR: assert property (cmd_error |-> cmd_valid)
		else $error("refusal pulse without command");
	AST_ACT_OPENS: assert property (s_act |-> s_open_row)
		else $error("activate did not open its row");
	AST_ACT_IDLE: assert property (s_act |-> !open_q[cmd.ba])
		else $error("activate taken on an open bank");
	AST_ACCESS_OPEN: assert property (ok && rw |-> open_q[cmd.ba])
		else $error("access taken on a closed bank");
	AST_HOLD: assert property (!cmd_valid |-> $stable(bank_open))
		else $error("bank state moved without a command");
	AST_DESEL: assert property (ok && cmd.code inside {CMD_DES, CMD_NOP}
		|-> $stable(bank_open))
		else $error("idle command changed bank state");
	AST_PRE_ONE: assert property (ok && cmd.code == CMD_PRE
		|-> !bank_open[cmd.ba] && bank_pre[cmd.ba])
		else $error("precharge did not close its bank");
	AST_PRE_ALL: assert property (ok && cmd.code == CMD_PREA |-> bank_open == '0)
		else $error("precharge all left a bank open");
	AST_AUTO_PRE: assert property (ok && rw && cmd.auto_pre
		|-> !bank_open[cmd.ba] && bank_pre[cmd.ba])
		else $error("auto precharge not started");
	AST_BEAT: assert property (wr_beat_valid |=> arr_wr_valid
		&& arr_wr_be == ~$past(wr_beat_mask) && arr_wr_data == $past(wr_beat_data))
		else $error("write beat mask or data wrong");
	AST_SREF: assert property (ok && cmd.code == CMD_SRE
		|-> ##[0:1] power_state == PW_SREF)
		else $error("self refresh not entered");
	AST_EXIT: assert property (ok && cmd.code inside {CMD_SRX, CMD_PDX}
		|-> ##[0:1] power_state == PW_RUN)
		else $error("low power state not left");
endmodule : dcd_decoder_assertions
bind dcd_decoder dcd_decoder_assertions i_dcd_decoder_assertions (.sys_clk, .reset_n,
	.wr_beat_valid, .wr_beat_data, .wr_beat_mask, .cmd_valid, .cmd, .cmd_error, .open_row,
	.bank_open, .bank_pre, .power_state, .arr_wr_valid, .arr_wr_data, .arr_wr_be);

// ==== sim/testbench.sv ====
// Purpose: self-checking bench of the command decoder
// Assumes: 250 MHz core clock, 160 ns link clock from the model
// Notes:   expected commands and beats are noted in queues
`timescale 1ns/100ps
module testbench;
	import dcd_pkg::*;
	logic sys_clk = 1'b0, reset_n = 1'b0, ck_in, otf_en = 1'b1, fixed_bc4 = 1'b0;
	logic wr_beat_valid = 1'b0, cmd_valid, cmd_error, arr_wr_valid, pend = 1'b0, ee, r;
	logic [DQ_W-1:0] wr_beat_data = '0, arr_wr_data;
	logic [DM_W-1:0] wr_beat_mask = '0, arr_wr_be;
	logic [ADDR_W-1:0] open_row, pend_row, rows [NUM_BANKS], row_q[$];
	logic [NUM_BANKS-1:0] bank_open, bank_pre;
	logic [15:0] lfsr_q = 16'hD56F;
	dcd_pins_type pins;
	dcd_cmd_type cmd, e, exp_q[$];
	dcd_pwr_type power_state;
	logic err_q[$];
	logic [DQ_W-1:0] dat_q[$];
	logic [DM_W-1:0] be_q[$];
	int bad_count = 0, checked = 0, cycles = 0;
	always #2 sys_clk = ~sys_clk;
	dcd_ctl_model i_dcd_ctl_model (.sys_clk(sys_clk), .ck_in(ck_in), .pins(pins));
	dcd_decoder i_dcd_decoder (
		.sys_clk(sys_clk), .reset_n(reset_n), .ck_in(ck_in), .pins(pins),
		.otf_en(otf_en), .fixed_bc4(fixed_bc4), .wr_beat_valid(wr_beat_valid),
		.wr_beat_data(wr_beat_data), .wr_beat_mask(wr_beat_mask), .cmd_valid(cmd_valid),
		.cmd(cmd), .cmd_error(cmd_error), .open_row(open_row), .bank_open(bank_open),
		.bank_pre(bank_pre), .power_state(power_state), .arr_wr_valid(arr_wr_valid),
		.arr_wr_data(arr_wr_data), .arr_wr_be(arr_wr_be));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	task automatic chk(input logic ok, input string m);
		checked++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask : chk
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict
	// queue one command: c is cke, cs, ras, cas, we; row bits are random
	task automatic op(input logic [4:0] c, input logic [2:0] ba, input logic a10, a12,
			input dcd_cmd_code_type code, input logic err, input logic bc4);
		dcd_pins_type p;
		dcd_cmd_type x;
		lfsr_q = lfsr(lfsr_q);
		p = {c, ba, lfsr_q[12:0]};
		p.addr[AP_BIT] = a10;
		p.addr[BC_BIT] = a12;
		if (code == CMD_ACT && !err) rows[ba] = p.addr;
		x = '0;
		x.code = code;
		x.ba = ba;
		x.addr = p.addr;
		row_q.push_back(rows[ba]);
		x.auto_pre = a10;
		x.bc4 = bc4;
		i_dcd_ctl_model.push(p);
		exp_q.push_back(x);
		err_q.push_back(err);
	endtask : op
	// wait for all noted commands, bounded
	task automatic flush(input string name);
		for (int i = 0; i < 4000 && exp_q.size() != 0; i++) @(negedge sys_clk);
		repeat (3) @(negedge sys_clk);
		chk(exp_q.size() == 0, "commands missing");
		$display("test %s done", name);
	endtask : flush
	// take the oldest note whenever a command or beat appears
	always @(negedge sys_clk) begin
		if (pend) chk(open_row === pend_row, "open row");
		pend = 1'b0;
		if (cmd_valid === 1'b1 && !(cmd.code === CMD_DES && cmd_error === 1'b0 &&
				(exp_q.size() == 0 || exp_q[0].code !== CMD_DES))) begin
			if (exp_q.size() == 0) begin
				chk(1'b0, "unexpected command");
			end else begin
				e = exp_q.pop_front();
				ee = err_q.pop_front();
				r = e.code inside {CMD_RD, CMD_WR};
				chk(cmd.code === e.code && cmd_error === ee, "command");
				chk(cmd.ba === e.ba && cmd.addr === e.addr, "fields");
				chk(!r || {cmd.bc4, cmd.auto_pre} === {e.bc4, e.auto_pre}, "burst");
				pend = (r || e.code == CMD_ACT) && !ee;
				pend_row = row_q.pop_front();
			end
		end
		if (arr_wr_valid === 1'b1) begin
			chk(dat_q.size() != 0 && arr_wr_data === dat_q[0], "beat data");
			chk(be_q.size() != 0 && arr_wr_be === be_q[0], "beat enables");
			if (dat_q.size() != 0) dat_q.pop_front();
			if (be_q.size() != 0) be_q.pop_front();
		end
	end
	// cut a hang short
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			print_verdict();
		end
	end
	initial begin
		repeat (12) @(negedge sys_clk);
		reset_n = 1'b1;
		op(5'h18, 3'h0, 1'b0, 1'b0, CMD_PDX, 1'b0, 1'b0);
		// open two banks; a second row in an open bank is refused
		op(5'h13, 3'h2, 1'b0, 1'b0, CMD_ACT, 1'b0, 1'b0);
		op(5'h13, 3'h5, 1'b0, 1'b0, CMD_ACT, 1'b0, 1'b0);
		op(5'h13, 3'h2, 1'b0, 1'b0, CMD_ACT, 1'b1, 1'b0);
		op(5'h17, 3'h2, 1'b0, 1'b0, CMD_NOP, 1'b0, 1'b0);
		op(5'h18, 3'h2, 1'b0, 1'b0, CMD_DES, 1'b0, 1'b0);
		flush("open");
		chk(bank_open === 8'h24 && bank_pre === 8'h00, "open banks");
		// chop chosen per command, then by fixed length
		op(5'h14, 3'h2, 1'b0, 1'b0, CMD_WR, 1'b0, 1'b1);
		op(5'h15, 3'h5, 1'b0, 1'b1, CMD_RD, 1'b0, 1'b0);
		flush("burst");
		otf_en = 1'b0;
		fixed_bc4 = 1'b1;
		op(5'h15, 3'h5, 1'b0, 1'b1, CMD_RD, 1'b0, 1'b1);
		op(5'h15, 3'h0, 1'b0, 1'b1, CMD_RD, 1'b1, 1'b1);
		op(5'h10, 3'h0, 1'b0, 1'b0, CMD_MRS, 1'b1, 1'b0);
		op(5'h15, 3'h5, 1'b1, 1'b0, CMD_RD, 1'b0, 1'b1);
		op(5'h14, 3'h2, 1'b0, 1'b0, CMD_WR, 1'b0, 1'b1);
		flush("auto precharge");
		chk(bank_open === 8'h04 && bank_pre === 8'h20, "auto precharge");
		// repeated precharge is taken; activate while precharging is refused
		op(5'h12, 3'h2, 1'b0, 1'b0, CMD_PRE, 1'b0, 1'b0);
		op(5'h12, 3'h2, 1'b0, 1'b0, CMD_PRE, 1'b0, 1'b0);
		op(5'h13, 3'h2, 1'b0, 1'b0, CMD_ACT, 1'b1, 1'b0);
		flush("precharge");
		chk(bank_open === 8'h00 && bank_pre[2] === 1'b1, "bank closed");
		repeat (320) @(negedge sys_clk); // precharge period before activate
		chk(bank_pre === 8'h00, "precharge ended");
		op(5'h13, 3'h1, 1'b0, 1'b0, CMD_ACT, 1'b0, 1'b0);
		op(5'h13, 3'h3, 1'b0, 1'b0, CMD_ACT, 1'b0, 1'b0);
		op(5'h12, 3'h0, 1'b1, 1'b0, CMD_PREA, 1'b0, 1'b0);
		flush("precharge all");
		chk(bank_open === 8'h00, "all closed");
		repeat (320) @(negedge sys_clk);
		// idle state commands, then low power entry and exit
		op(5'h10, 3'h0, 1'b0, 1'b0, CMD_MRS, 1'b0, 1'b0);
		op(5'h11, 3'h0, 1'b0, 1'b0, CMD_REF, 1'b0, 1'b0);
		op(5'h16, 3'h0, 1'b1, 1'b0, CMD_ZQL, 1'b0, 1'b0);
		op(5'h16, 3'h0, 1'b0, 1'b0, CMD_ZQS, 1'b0, 1'b0);
		op(5'h02, 3'h0, 1'b0, 1'b0, CMD_NOP, 1'b1, 1'b0);
		op(5'h13, 3'h0, 1'b0, 1'b0, CMD_NOP, 1'b1, 1'b0);
		op(5'h01, 3'h0, 1'b0, 1'b0, CMD_SRE, 1'b0, 1'b0);
		flush("self refresh");
		chk(power_state === PW_SREF, "in self refresh");
		op(5'h17, 3'h0, 1'b0, 1'b0, CMD_SRX, 1'b0, 1'b0);
		op(5'h07, 3'h0, 1'b0, 1'b0, CMD_PDE, 1'b0, 1'b0);
		flush("power down");
		chk(power_state === PW_PDN, "in power down");
		op(5'h18, 3'h0, 1'b0, 1'b0, CMD_PDX, 1'b0, 1'b0);
		flush("wake");
		chk(power_state === PW_RUN, "running");
		// back to back beats with every mask pair
		for (int i = 0; i < 8; i++) begin
			lfsr_q = lfsr(lfsr_q);
			wr_beat_valid = 1'b1;
			wr_beat_data = lfsr_q;
			wr_beat_mask = i[1:0];
			dat_q.push_back(lfsr_q);
			be_q.push_back(~i[1:0]);
			@(negedge sys_clk);
		end
		wr_beat_valid = 1'b0;
		repeat (4) @(negedge sys_clk);
		chk(dat_q.size() == 0, "beats missing");
		$display("test write mask done");
		print_verdict();
	end
endmodule : testbench
